// ### include/pbs_pkg.sv
package pbs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int BC_W = 4;
   localparam int MEM_WORDS = 256;
   // fixed-latency pipe length for every read word, burst beats included
   localparam int READ_LAT = 2;
   localparam logic [1:0] READ_LAT_CNT = 2'h2;
   // fixed wait states on each address phase
   localparam int WAIT_STATES = 1;
   localparam logic [1:0] WAIT_CNT = 2'h1;
   localparam int MAX_PEND = 4;
   localparam logic [2:0] MAX_PEND_CNT = 3'h4;
   // line of 64 bytes = 16 words, low 4 word-address bits wrap
   localparam int LINE_BITS = 4;
   localparam logic [BC_W-1:0] BC_ONE = 4'h1;
   localparam logic [BC_W-1:0] BC_ZERO = 4'h0;
   localparam logic HOLD_STABLE_DEF = 1'b0;
   typedef enum logic [3:0] {
      PBS_IDLE = 4'b0001,
      PBS_WAIT = 4'b0010,
      PBS_WBURST = 4'b0100,
      PBS_RBURST = 4'b1000
   } pbs_state_t;
endpackage

// ### design/pbs_read_pipe.sv
`timescale 1ns/1ps
module pbs_read_pipe
   import pbs_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst, // async reset
   input wire logic issue, // read word leaves the memory stage
   input wire logic [pbs_pkg::DATA_W-1:0] issueData, // word read
   output logic outValid, // word ready, one cycle
   output logic [pbs_pkg::DATA_W-1:0] outData // word
);
   import pbs_pkg::*;
   typedef struct packed {
      logic [READ_LAT-1:0] vld;
      logic [READ_LAT-1:0][DATA_W-1:0] dat;
   } pbs_pipe_t;
   pbs_pipe_t s_q, s_d;
   // fixed delay line keeps words in issue order
   always_comb begin
      s_d = s_q;
      s_d.vld[0] = issue;
      s_d.dat[0] = issueData;
      for (int i = 1; i < READ_LAT; i++) begin
         s_d.vld[i] = s_q.vld[i-1];
         s_d.dat[i] = s_q.dat[i-1];
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign outValid = s_q.vld[READ_LAT-1];
   assign outData = s_q.dat[READ_LAT-1];
endmodule

// ### design/pbs_slave.sv
`timescale 1ns/1ps
module pbs_slave
   import pbs_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst, // async reset, active high
   input wire logic [pbs_pkg::ADDR_W-1:0] address, // word address
   input wire logic read, // read request
   input wire logic write, // write request
   input wire logic [pbs_pkg::DATA_W-1:0] writeWord, // write data
   input wire logic [pbs_pkg::BE_W-1:0] byteLaneSelect, // byte enables
   input wire logic [pbs_pkg::BC_W-1:0] burstLengthIn, // burst length
   input wire logic burstFirstCycle, // first cycle of burst marker
   input wire logic lineWrap, // wrap burst addresses within line
   input wire logic holdBurstFieldsStable, // fields held steady whole burst
   output logic transferStall, // wait request
   output logic [pbs_pkg::DATA_W-1:0] readWord, // read data
   output logic readReturnValid // read data valid, one cycle
);
   import pbs_pkg::*;
   typedef struct packed {
      pbs_state_t st;
      logic [1:0] waitCnt;
      logic [ADDR_W-1:0] curAddr;
      logic [ADDR_W-1:0] baseAddr;
      logic [BC_W-1:0] wordsLeft;
      logic [BC_W-1:0] rdIssueLeft;
      logic [BE_W-1:0] rdLanes;
      logic wrapQ;
      logic [2:0] pend;
      logic stall;
      logic rvalid;
      logic [DATA_W-1:0] rword;
   } pbs_state_s_t;
   pbs_state_s_t s_q, s_d;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic memWe;
   logic [ADDR_W-1:0] memWAddr;
   logic [DATA_W-1:0] memWData;
   logic [BE_W-1:0] memWBe;
   logic issue;
   logic [DATA_W-1:0] issueData;
   logic pipeValid;
   logic [DATA_W-1:0] pipeData;
   logic accept;
   logic retire;
   logic [ADDR_W-1:0] nextAddr;

   function automatic logic [DATA_W-1:0] laneMask(input logic [BE_W-1:0] be, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      r = '0;
      for (int b = 0; b < BE_W; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // next address: linear, or wrap within the line
   always_comb begin
      nextAddr = s_q.curAddr + 8'h01;
      if (s_q.wrapQ) begin
         nextAddr = {s_q.curAddr[ADDR_W-1:LINE_BITS], 4'h0 | (s_q.curAddr[LINE_BITS-1:0] + 4'h1)};
      end
   end

   // a command is taken once the address phase ends: no stall, waits done
   assign accept = (read || write) && !s_q.stall && (s_q.st == PBS_WAIT) && (s_q.waitCnt == WAIT_CNT);

   pbs_read_pipe u_pipe (
      .ref_clk(ref_clk),
      .rst(rst),
      .issue(issue),
      .issueData(issueData),
      .outValid(pipeValid),
      .outData(pipeData)
   );
   assign retire = pipeValid;

   always_comb begin
      s_d = s_q;
      memWe = 1'b0;
      memWAddr = s_q.curAddr;
      memWData = writeWord;
      memWBe = byteLaneSelect;
      issue = 1'b0;
      issueData = '0;
      s_d.rvalid = pipeValid;
      s_d.rword = pipeData;
      unique case (s_q.st)
         PBS_IDLE: begin
            s_d.waitCnt = 2'h0;
            if ((read || write) && s_q.pend < MAX_PEND_CNT) begin
               s_d.st = PBS_WAIT;
            end
         end
         PBS_WAIT: begin
            // count the fixed wait states of the address phase
            if (!(read || write)) begin
               s_d.st = PBS_IDLE;
            end else if (s_q.waitCnt != WAIT_CNT) begin
               s_d.waitCnt = s_q.waitCnt + 2'h1;
            end else if (!s_q.stall) begin
               // capture address and length exactly once per burst
               s_d.baseAddr = address;
               s_d.curAddr = address;
               s_d.wrapQ = lineWrap;
               s_d.waitCnt = 2'h0;
               if (write) begin
                  memWe = 1'b1;
                  memWAddr = address;
                  if (burstLengthIn > BC_ONE) begin
                     s_d.wordsLeft = burstLengthIn - BC_ONE;
                     s_d.st = PBS_WBURST;
                     s_d.curAddr = address + 8'h01;
                     if (lineWrap) begin
                        s_d.curAddr = {address[ADDR_W-1:LINE_BITS], 4'h0 | (address[LINE_BITS-1:0] + 4'h1)};
                     end
                  end else begin
                     s_d.st = PBS_IDLE;
                  end
               end else begin
                  s_d.rdLanes = byteLaneSelect;
                  s_d.rdIssueLeft = (burstLengthIn == BC_ZERO) ? BC_ONE : burstLengthIn;
                  s_d.st = PBS_RBURST;
               end
            end
         end
         PBS_WBURST: begin
            // write dropped: burst pauses; address ignored after first beat
            if (write && !s_q.stall) begin
               memWe = 1'b1;
               memWAddr = s_q.curAddr;
               s_d.curAddr = nextAddr;
               s_d.wordsLeft = s_q.wordsLeft - BC_ONE;
               if (s_q.wordsLeft == BC_ONE) begin
                  s_d.st = PBS_IDLE;
               end
            end
         end
         PBS_RBURST: begin
            // one word a cycle into the latency pipe while room remains
            if (s_q.pend < MAX_PEND_CNT) begin
               issue = 1'b1;
               issueData = laneMask(s_q.rdLanes, mem[s_q.curAddr]);
               s_d.curAddr = nextAddr;
               s_d.rdIssueLeft = s_q.rdIssueLeft - BC_ONE;
               if (s_q.rdIssueLeft == BC_ONE) begin
                  s_d.st = PBS_IDLE;
               end
            end
         end
         default: begin
            s_d.st = PBS_IDLE;
         end
      endcase
      s_d.pend = s_q.pend + {2'h0, issue} - {2'h0, retire};
      // stall while pending reads are at the bound, or a read burst is busy
      // idle also stalls: a low stall must only show on the capturing edge
      s_d.stall = (s_d.pend >= MAX_PEND_CNT) || (s_d.st == PBS_IDLE) || (s_d.st == PBS_RBURST)
         || (s_d.st == PBS_WAIT && s_d.waitCnt != WAIT_CNT);
   end

   // byte-lane write port; reads carry no side effect
   always_ff @(posedge ref_clk) begin
      if (memWe) begin
         for (int b = 0; b < BE_W; b++) begin
            if (memWBe[b]) begin
               mem[memWAddr][b*8 +: 8] <= memWData[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= PBS_IDLE;
         s_q.stall <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign transferStall = s_q.stall;
   assign readWord = s_q.rword;
   assign readReturnValid = s_q.rvalid;
endmodule

// ### sim/pbs_slave_checker.sv
`timescale 1ns/1ps
module pbs_slave_checker
   import pbs_pkg::*;
(
   input wire logic ref_clk, // clk
   input wire logic rst, // reset
   input wire logic read, // rd
   input wire logic write, // wr
   input wire logic [pbs_pkg::BC_W-1:0] burstLengthIn, // len
   input wire logic transferStall, // stall
   input wire logic readReturnValid // valid
);
   logic [1:0] age_q;
   logic [5:0] pend_q;
   logic acc;
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // a read counts as taken only after its wait edges
   assign acc = read && !transferStall && age_q[1];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         age_q <= 2'h0;
         pend_q <= 6'h0;
      end else begin
         age_q <= read ? (age_q | {age_q[0], 1'b1}) : 2'h0;
         pend_q <= pend_q + (acc ? 6'(burstLengthIn) : 6'h0) - 6'(readReturnValid);
      end
   end
   rst_quiet_a: assert property (disable iff (1'b0) rst |-> !readReturnValid && transferStall)
      else $error("reset outputs");
   wake_quiet_a: assert property ($fell(rst) |-> !readReturnValid [*3])
      else $error("valid after reset");
   rd_wait_a: assert property ($rose(read) |=> transferStall)
      else $error("no wait state");
   stall_end_a: assert property ((read || write) && transferStall |-> ##[1:40] !transferStall)
      else $error("stall too long");
   first_word_a: assert property (acc && pend_q == 6'h0 |=> !readReturnValid [*3] ##1 readReturnValid)
      else $error("read latency");
   no_owed_a: assert property (readReturnValid |-> pend_q != 6'h0)
      else $error("extra word");
   word_gap_a: assert property (pend_q != 6'h0 |-> ##[0:60] readReturnValid)
      else $error("word lost");
   last_word_a: assert property (readReturnValid && pend_q == 6'h1 && !acc |=> !readReturnValid)
      else $error("word after last");
endmodule
bind pbs_slave pbs_slave_checker i_chk (.ref_clk, .rst, .read, .write, .burstLengthIn,
   .transferStall, .readReturnValid);

// ### sim/pbs_master_model.sv
`timescale 1ns/1ps
module pbs_master_model
   import pbs_pkg::*;
(
   input wire logic ref_clk, // clk
   input wire logic transferStall, // stall
   output logic [pbs_pkg::ADDR_W-1:0] address, // addr
   output logic read, // rd
   output logic write, // wr
   output logic [pbs_pkg::DATA_W-1:0] writeWord, // data
   output logic [pbs_pkg::BE_W-1:0] byteLaneSelect, // lanes
   output logic [pbs_pkg::BC_W-1:0] burstLengthIn, // len
   output logic burstFirstCycle, // first
   output logic lineWrap, // wrap
   output logic holdBurstFieldsStable // hold
);
   initial begin
      {address, read, write, writeWord, byteLaneSelect} = '0;
      {burstLengthIn, burstFirstCycle, lineWrap} = '0;
      holdBurstFieldsStable = HOLD_STABLE_DEF;
   end
   // released lines flip so a stale value never looks valid
   task automatic rel();
      read = 1'b0;
      write = 1'b0;
      address = ~address;
      writeWord = ~writeWord;
   endtask
   // all fields but burstFirstCycle stay put while stalled; burstFirstCycle drops after one cycle
   task automatic hold(input int skip);
      int k;
      k = 0;
      while ((transferStall || k < skip) && k < 300) begin
         @(negedge ref_clk);
         burstFirstCycle = 1'b0;
         k++;
      end
      @(negedge ref_clk);
   endtask
   task automatic go(input logic [ADDR_W-1:0] a, input logic [BC_W-1:0] n, input logic w, input logic [BE_W-1:0] be);
      @(negedge ref_clk);
      address = a;
      burstLengthIn = n;
      lineWrap = w;
      byteLaneSelect = be;
      burstFirstCycle = 1'b1;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [BC_W-1:0] n, input logic w);
      go(a, n, w, 4'hF);
      read = 1'b1;
      hold(2);
      rel();
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [BC_W-1:0] n, input logic w,
         input logic [BE_W-1:0] be, input logic [DATA_W-1:0] base);
      for (int i = 0; i < n; i++) begin
         if (i == 0) go(a, n, w, be);
         write = 1'b1;
         writeWord = base + 32'(i);
         hold(i == 0 ? 2 : 0);
         address = ~a;
         burstLengthIn = ~n;
         if (i == 0 && n > 2) begin
            write = 1'b0;
            writeWord = ~writeWord;
            @(negedge ref_clk);
         end
      end
      rel();
   endtask
endmodule

// ### sim/pbs_slave_tb_top.sv
`timescale 1ns/1ps
module pbs_slave_tb_top
   import pbs_pkg::*;
;
   typedef struct packed {
      logic [ADDR_W-1:0] a;
      logic [BC_W-1:0] n;
      logic w;
      logic [BE_W-1:0] be;
   } pbs_row_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b0;
   logic [ADDR_W-1:0] address;
   logic read, write, burstFirstCycle, lineWrap, holdBurstFieldsStable, transferStall, readReturnValid;
   logic [DATA_W-1:0] writeWord, readWord;
   logic [BE_W-1:0] byteLaneSelect;
   logic [BC_W-1:0] burstLengthIn;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [DATA_W-1:0] got [$];
   logic [DATA_W-1:0] exq [$];
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   pbs_row_t rows [5] = '{'{8'h10, 4'h1, 1'b0, 4'hF}, '{8'h20, 4'h8, 1'b0, 4'hF},
      '{8'h3D, 4'h8, 1'b1, 4'hF}, '{8'h20, 4'h4, 1'b0, 4'h5}, '{8'h3E, 4'h3, 1'b1, 4'hC}};
   always #2 ref_clk = ~ref_clk;
   pbs_slave i_dut (.ref_clk, .rst, .address, .read, .write, .writeWord, .byteLaneSelect, .burstLengthIn,
      .burstFirstCycle, .lineWrap, .holdBurstFieldsStable, .transferStall, .readWord, .readReturnValid);
   pbs_master_model i_mst (.ref_clk, .transferStall, .address, .read, .write, .writeWord, .byteLaneSelect,
      .burstLengthIn, .burstFirstCycle, .lineWrap, .holdBurstFieldsStable);
   task automatic finish_test();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // valid stands a whole cycle, so mid-cycle sampling avoids edge races
   always @(negedge ref_clk) begin
      cyc++;
      if (readReturnValid === 1'b1) got.push_back(readWord);
      if (cyc == 5000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(input string s, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", s, e, g);
      end
   endtask
   function automatic logic [ADDR_W-1:0] wa(input pbs_row_t r, input int i);
      return r.w ? {r.a[7:4], r.a[3:0] + 4'(i)} : r.a + 8'(i);
   endfunction
   task automatic wr(input pbs_row_t r, input logic [DATA_W-1:0] base);
      logic [DATA_W-1:0] d;
      i_mst.wr(r.a, r.n, r.w, r.be, base);
      for (int i = 0; i < r.n; i++) begin
         d = base + 32'(i);
         for (int b = 0; b < BE_W; b++) begin
            if (r.be[b]) mem[wa(r, i)][8*b +: 8] = d[8*b +: 8];
         end
      end
   endtask
   task automatic rdr(input pbs_row_t r);
      i_mst.rd(r.a, r.n, r.w);
      for (int i = 0; i < r.n; i++) exq.push_back(mem[wa(r, i)]);
   endtask
   task automatic drain();
      int k;
      k = 0;
      while (got.size() < exq.size() && k < 200) begin
         @(negedge ref_clk);
         k++;
      end
      repeat (4) @(negedge ref_clk);
      chk("words", 32'(exq.size()), 32'(got.size()));
      while (exq.size() > 0 && got.size() > 0) chk("rdata", exq.pop_front(), got.pop_front());
      exq = {};
      got = {};
   endtask
   initial begin
      #1;
      rst = 1'b1;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      foreach (rows[j]) begin
         wr(rows[j], 32'hA5000000 + 32'(j << 8));
         rdr(rows[j]);
         drain();
      end
      rdr('{8'h20, 4'h2, 1'b0, 4'hF});
      rdr('{8'h3D, 4'h3, 1'b1, 4'hF});
      drain();
      rdr('{8'h30, 4'h8, 1'b0, 4'hF});
      @(negedge ref_clk);
      rst = 1'b1;
      @(negedge ref_clk);
      got = {};
      exq = {};
      chk("valid", 32'h0, 32'(readReturnValid));
      chk("stall", 32'(transferStall), 32'h1);
      rst = 1'b0;
      repeat (12) @(negedge ref_clk);
      chk("late", 32'(got.size()), 32'h0);
      finish_test();
   end
endmodule
